//--- hdl/kra_pkg.sv
// Constants and carrier types for the auto-negotiation register bank.
// Assumes a single 25 MHz clock domain shared with the negotiation engine.
package kra_pkg;
    // =========================================================
    // Register bus
    localparam int AW = 10;
    localparam int DW = 32;
    localparam logic [1:0] BYTE_LANE_PAD = 2'h0;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FEC_UNCORR = 8'hb4;
    localparam logic [7:0] IDX_CTRL = 8'hc0;
    localparam logic [7:0] IDX_STROBE = 8'hc1;
    localparam logic [7:0] IDX_STATUS = 8'hc2;
    localparam logic [7:0] IDX_UBP_LO = 8'hc3;
    // =========================================================
    // Control word fields
    localparam int CTL_AN_EN = 0;
    localparam int CTL_BASE_SRC = 1;
    localparam int CTL_NP_SRC = 2;
    localparam int CTL_LOC_RF = 3;
    localparam int CTL_FORCE_NONCE = 4;
    localparam int CTL_OVR_EN = 5;
    localparam int CTL_TECH_LSB = 16;
    localparam int CTL_TECH_MSB = 21;
    localparam int CTL_CORR_LSB = 24;
    localparam int CTL_CORR_MSB = 25;
    localparam int CTL_PAUSE_LSB = 28;
    localparam int CTL_PAUSE_MSB = 30;
    localparam int TECH_10G_KR = 2;
    localparam logic CTL_AN_EN_RESET = 1'h1;
    // =========================================================
    // Strobe word fields
    localparam int STB_RESET = 0;
    localparam int STB_RESTART = 4;
    localparam int STB_NP_READY = 8;
    // =========================================================
    // Status word fields
    localparam int ST_PAGE_RX = 1;
    localparam int ST_DONE = 2;
    localparam int ST_RF_ADV = 3;
    localparam int ST_RX_IDLE = 4;
    localparam int ST_ABILITY = 5;
    localparam int ST_LINK = 6;
    localparam int ST_LP_ABILITY = 7;
    localparam int ST_FEC_NEG = 8;
    localparam int ST_FAIL = 9;
    localparam int ST_READY_LSB = 12;
    localparam int ST_READY_MSB = 17;
    localparam logic AN_BUILT_IN = 1'h1;
    // =========================================================
    // User base page word
    localparam int UBP_W = 16;
    localparam int UBP_ECHO_LSB = 5;
    localparam int UBP_ECHO_MSB = 9;
    localparam int UBP_ACK = 14;
    localparam logic [15:0] UBP_RESET = 16'h0000;
    localparam logic [15:0] UBP_ENGINE_MASK = 16'hbc1f;
    // =========================================================
    // Carriers
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } kra_bus_t;
    typedef struct packed {
        logic fec_uncorr;
        logic page_rx;
        logic done;
        logic rf_sent;
        logic rx_idle;
        logic link_up;
        logic lp_ability;
        logic fec_resolved;
        logic seq_fail;
        logic [5:0] link_ready;
        logic tx_in_neg;
        logic np_taken;
        logic local_rf;
    } kra_eng_stat_t;
    typedef struct packed {
        logic an_en;
        logic user_base;
        logic user_next;
        logic force_nonce;
        logic ovr_active;
        logic [5:0] tech;
        logic [1:0] corr;
        logic [2:0] pause;
        logic [15:0] ubp;
        logic reset_pulse;
        logic restart_pulse;
        logic np_ready;
    } kra_eng_ctrl_t;
endpackage

//--- hdl/kra_sat_counter.sv
// Saturating event counter that clears when software reads it.
// Assumes inc_i and clr_i are one-cycle pulses in the clock_i domain.
module kra_sat_counter
    import kra_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic inc_i,
    input wire logic clr_i,
    output logic [W-1:0] count_o
);
    // =========================================================
    // Counter
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    wire at_max = &count_reg;
    wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

    // Event in the clearing cycle is kept as a count of one
    always_comb begin
        count_next = count_reg;
        if (clr_i) begin
            count_next = inc_i ? one : '0;
        end else if (inc_i && !at_max) begin
            count_next = count_reg + one;
        end
    end

    // Holds at the top instead of wrapping
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;
endmodule

//--- hdl/kra_regs.sv
// Control and status registers for the backplane auto-negotiation engine.
// Assumes the engine sits on clock_i and drives eng_i synchronously.
// Operation
// - Count uncorrectable FEC blocks in a 32-bit counter, one per block.
// - Control bit 0 enables auto-negotiation and resets to 1.
// - Base-page-source bit selects user base page over generated pages.
// - Next-page-source bit selects user next page over null messages.
// - Read-only control bit shows local remote fault signalling.
// - Nonce-forcing bit makes the transmitter send a forced nonce.
// - Override fields replace advertised values only while override enabled.
// - Reset strobe resets all negotiation machines and clears itself.
// - Restart strobe restarts transmit machine, self-clears, only while negotiating.
// - Next-page-ready set by software, sent by device, then cleared by device.
// - Page-received flag sets on arrival and clears on status read.
// - Completion flag reads 1 once negotiation has finished.
// - Remote-fault-advertised flag sets when sent, clears on status read.
// - Receive-idle flag reads 1 while receive machine idles on foreign data.
// - Local-ability bit is constant 1 in builds with negotiation.
// - Link status bit reads link state; held value clears on status read.
// - Partner-ability bit shows the partner can negotiate.
// - FEC-negotiated bit only when complete and resolved link uses FEC.
// - Failure bit shows the sequencer detected a negotiation failure.
// - Six-bit one-hot field shows technology with idle and link good.
// - User base page word fields; engine supplies echoed nonce and ack.
// - Technology override sits in control bits 21:16, bit 18 is 10G KR.
module kra_regs
    import kra_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire kra_bus_t bus_i,
    output logic [DW-1:0] rdata_o,
    input wire kra_eng_stat_t eng_i,
    output kra_eng_ctrl_t eng_o
);
    // =========================================================
    // Reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Release through two flops so the bank leaves reset cleanly
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // =========================================================
    // Address decode
    wire [AW-1:0] a_fec = {IDX_FEC_UNCORR, BYTE_LANE_PAD};
    wire [AW-1:0] a_ctl = {IDX_CTRL, BYTE_LANE_PAD};
    wire [AW-1:0] a_stb = {IDX_STROBE, BYTE_LANE_PAD};
    wire [AW-1:0] a_sta = {IDX_STATUS, BYTE_LANE_PAD};
    wire [AW-1:0] a_ubp = {IDX_UBP_LO, BYTE_LANE_PAD};

    wire hit_fec = bus_i.addr == a_fec;
    wire hit_ctl = bus_i.addr == a_ctl;
    wire hit_stb = bus_i.addr == a_stb;
    wire hit_sta = bus_i.addr == a_sta;
    wire hit_ubp = bus_i.addr == a_ubp;

    wire wr_ctl = bus_i.wr && hit_ctl;
    wire wr_stb = bus_i.wr && hit_stb;
    wire wr_ubp = bus_i.wr && hit_ubp;
    wire rd_fec = bus_i.rd && hit_fec;
    wire rd_sta = bus_i.rd && hit_sta;
    wire [DW-1:0] wd = bus_i.wdata;

    // =========================================================
    // Uncorrectable block counter
    logic [DW-1:0] fec_count;

    kra_sat_counter #(
        .W(DW)
    ) u_fec_count (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .inc_i(eng_i.fec_uncorr),
        .clr_i(rd_fec),
        .count_o(fec_count)
    );

    // =========================================================
    // Control word
    logic an_en_reg;
    logic base_src_reg;
    logic np_src_reg;
    logic force_nonce_reg;
    logic ovr_en_reg;
    logic [5:0] tech_reg;
    logic [1:0] corr_reg;
    logic [2:0] pause_reg;
    logic [UBP_W-1:0] ubp_reg;

    // Plain software-written storage
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            an_en_reg <= CTL_AN_EN_RESET;
            base_src_reg <= 1'b0;
            np_src_reg <= 1'b0;
            force_nonce_reg <= 1'b0;
            ovr_en_reg <= 1'b0;
            tech_reg <= '0;
            corr_reg <= '0;
            pause_reg <= '0;
            ubp_reg <= UBP_RESET;
        end else begin
            if (wr_ctl) begin
                an_en_reg <= wd[CTL_AN_EN];
                base_src_reg <= wd[CTL_BASE_SRC];
                np_src_reg <= wd[CTL_NP_SRC];
                force_nonce_reg <= wd[CTL_FORCE_NONCE];
                ovr_en_reg <= wd[CTL_OVR_EN];
                tech_reg <= wd[CTL_TECH_MSB:CTL_TECH_LSB];
                corr_reg <= wd[CTL_CORR_MSB:CTL_CORR_LSB];
                pause_reg <= wd[CTL_PAUSE_MSB:CTL_PAUSE_LSB];
            end
            if (wr_ubp) begin
                ubp_reg <= wd[UBP_W-1:0];
            end
        end
    end

    // =========================================================
    // Strobes
    logic np_ready_reg;

    // Software set and engine clear in one cycle: the set wins
    wire np_set = wr_stb && wd[STB_NP_READY];
    wire np_ready_next = np_set || (np_ready_reg && !eng_i.np_taken);

    // Restart only reaches the engine while it negotiates
    wire reset_next = wr_stb && wd[STB_RESET];
    wire restart_next = wr_stb && wd[STB_RESTART] && eng_i.tx_in_neg;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            np_ready_reg <= 1'b0;
        end else begin
            np_ready_reg <= np_ready_next;
        end
    end

    // =========================================================
    // Sticky status flags
    logic page_rx_reg;
    logic rf_adv_reg;
    logic link_held_reg;

    // Events in the read cycle survive the clear
    wire page_rx_next = eng_i.page_rx || (page_rx_reg && !rd_sta);
    wire rf_adv_next = eng_i.rf_sent || (rf_adv_reg && !rd_sta);
    wire link_next = eng_i.link_up || (link_held_reg && !rd_sta);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            page_rx_reg <= 1'b0;
            rf_adv_reg <= 1'b0;
            link_held_reg <= 1'b0;
        end else begin
            page_rx_reg <= page_rx_next;
            rf_adv_reg <= rf_adv_next;
            link_held_reg <= link_next;
        end
    end

    // =========================================================
    // Read data composition
    logic [DW-1:0] ctl_word;
    logic [DW-1:0] stb_word;
    logic [DW-1:0] sta_word;
    logic [DW-1:0] ubp_word;
    logic [DW-1:0] rdata_next;

    // Reserved bits read as zero
    always_comb begin
        ctl_word = '0;
        ctl_word[CTL_AN_EN] = an_en_reg;
        ctl_word[CTL_BASE_SRC] = base_src_reg;
        ctl_word[CTL_NP_SRC] = np_src_reg;
        ctl_word[CTL_LOC_RF] = eng_i.local_rf;
        ctl_word[CTL_FORCE_NONCE] = force_nonce_reg;
        ctl_word[CTL_OVR_EN] = ovr_en_reg;
        ctl_word[CTL_TECH_MSB:CTL_TECH_LSB] = tech_reg;
        ctl_word[CTL_CORR_MSB:CTL_CORR_LSB] = corr_reg;
        ctl_word[CTL_PAUSE_MSB:CTL_PAUSE_LSB] = pause_reg;
    end

    // Pulse strobes are never stored, so they read back 0
    always_comb begin
        stb_word = '0;
        stb_word[STB_NP_READY] = np_ready_reg;
    end

    // Live levels mixed with sticky flags
    always_comb begin
        sta_word = '0;
        sta_word[ST_PAGE_RX] = page_rx_reg;
        sta_word[ST_DONE] = eng_i.done;
        sta_word[ST_RF_ADV] = rf_adv_reg;
        sta_word[ST_RX_IDLE] = eng_i.rx_idle;
        sta_word[ST_ABILITY] = AN_BUILT_IN;
        sta_word[ST_LINK] = link_held_reg;
        sta_word[ST_LP_ABILITY] = eng_i.lp_ability;
        sta_word[ST_FEC_NEG] = eng_i.done && eng_i.fec_resolved;
        sta_word[ST_FAIL] = eng_i.seq_fail;
        sta_word[ST_READY_MSB:ST_READY_LSB] = eng_i.link_ready;
    end

    always_comb begin
        ubp_word = '0;
        ubp_word[UBP_W-1:0] = ubp_reg;
    end

    // Unmapped reads answer zero; reads never stall
    always_comb begin
        rdata_next = '0;
        if (bus_i.rd) begin
            case (1'b1)
                hit_fec: rdata_next = fec_count;
                hit_ctl: rdata_next = ctl_word;
                hit_stb: rdata_next = stb_word;
                hit_sta: rdata_next = sta_word;
                hit_ubp: rdata_next = ubp_word;
                default: rdata_next = '0;
            endcase
        end
    end

    // =========================================================
    // Registered outputs
    kra_eng_ctrl_t eng_next;

    // Overrides are masked so the engine never sees stale fields
    always_comb begin
        eng_next = '0;
        eng_next.an_en = wr_ctl ? wd[CTL_AN_EN] : an_en_reg;
        eng_next.user_base = wr_ctl ? wd[CTL_BASE_SRC] : base_src_reg;
        eng_next.user_next = wr_ctl ? wd[CTL_NP_SRC] : np_src_reg;
        eng_next.force_nonce = wr_ctl ? wd[CTL_FORCE_NONCE] : force_nonce_reg;
        eng_next.ovr_active = wr_ctl ? wd[CTL_OVR_EN] : ovr_en_reg;
        if (eng_next.ovr_active) begin
            eng_next.tech = wr_ctl ? wd[CTL_TECH_MSB:CTL_TECH_LSB] : tech_reg;
            eng_next.corr = wr_ctl ? wd[CTL_CORR_MSB:CTL_CORR_LSB] : corr_reg;
            eng_next.pause = wr_ctl ? wd[CTL_PAUSE_MSB:CTL_PAUSE_LSB] : pause_reg;
        end
        eng_next.ubp = (wr_ubp ? wd[UBP_W-1:0] : ubp_reg) & UBP_ENGINE_MASK;
        eng_next.reset_pulse = reset_next;
        eng_next.restart_pulse = restart_next;
        eng_next.np_ready = np_ready_next;
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            eng_o <= '0;
            eng_o.an_en <= CTL_AN_EN_RESET;
            rdata_o <= '0;
        end else begin
            eng_o <= eng_next;
            rdata_o <= rdata_next;
        end
    end

    // =========================================================
    // Assertions
    a_count_inc: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_i.fec_uncorr && !rd_fec && !(&fec_count)
        |=> fec_count == $past(fec_count) + 32'h1)
        else $error("uncorrectable count did not advance");

    a_count_sat: assert property (@(posedge clock_i) disable iff (!rst_n)
        (&fec_count) && !rd_fec |=> (&fec_count))
        else $error("uncorrectable count wrapped");

    a_count_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
        rd_fec && !eng_i.fec_uncorr |=> fec_count == 32'h0 && rdata_o == $past(fec_count))
        else $error("count not returned then cleared");

    a_enable_write: assert property (@(posedge clock_i) disable iff (!rst_n)
        wr_ctl |=> eng_o.an_en == $past(wd[CTL_AN_EN]) ##1 an_en_reg == eng_o.an_en)
        else $error("enable did not follow write");

    a_override_gate: assert property (@(posedge clock_i) disable iff (!rst_n)
        !eng_o.ovr_active |-> eng_o.tech == 6'h0 && eng_o.corr == 2'h0 && eng_o.pause == 3'h0)
        else $error("override fields leaked");

    a_reset_pulse: assert property (@(posedge clock_i) disable iff (!rst_n)
        wr_stb && wd[STB_RESET] |=> eng_o.reset_pulse ##1 !eng_o.reset_pulse || $past(reset_next))
        else $error("reset strobe not a single pulse");

    a_restart_gate: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_o.restart_pulse |-> $past(eng_i.tx_in_neg) && $past(wr_stb))
        else $error("restart outside negotiation");

    a_np_handshake: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_o.np_ready && eng_i.np_taken && !np_set |=> !eng_o.np_ready)
        else $error("next page ready not cleared");

    a_page_sticky: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_i.page_rx ##1 rd_sta |=> rdata_o[ST_PAGE_RX])
        else $error("page received flag lost");

    a_status_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
        rd_sta && !eng_i.rf_sent && !eng_i.page_rx |=> !rf_adv_reg && !page_rx_reg)
        else $error("status flags not cleared by read");

    a_fec_neg: assert property (@(posedge clock_i) disable iff (!rst_n)
        rd_sta |=> rdata_o[ST_FEC_NEG] == ($past(eng_i.done) && $past(eng_i.fec_resolved))
            && rdata_o[ST_ABILITY])
        else $error("status word composed wrongly");

    a_strobe_read: assert property (@(posedge clock_i) disable iff (!rst_n)
        bus_i.rd && hit_stb |=> rdata_o[STB_RESET] == 1'b0 && rdata_o[STB_RESTART] == 1'b0)
        else $error("strobe read back nonzero");

    a_restart_single: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_o.restart_pulse && !wr_stb |=> !eng_o.restart_pulse)
        else $error("restart strobe stuck high");

    a_np_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_o.np_ready && !eng_i.np_taken |=> eng_o.np_ready)
        else $error("next page ready dropped before taken");

    a_link_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
        link_held_reg && !rd_sta |=> link_held_reg)
        else $error("held link status lost without read");

    a_rf_sticky: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_i.rf_sent ##1 rd_sta |=> rdata_o[ST_RF_ADV])
        else $error("remote fault advertised flag lost");

    a_done_live: assert property (@(posedge clock_i) disable iff (!rst_n)
        rd_sta |=> rdata_o[ST_DONE] == $past(eng_i.done))
        else $error("completion flag not live");

    a_ready_field: assert property (@(posedge clock_i) disable iff (!rst_n)
        rd_sta |=> rdata_o[ST_READY_MSB:ST_READY_LSB] == $past(eng_i.link_ready))
        else $error("link ready field wrong");

    a_ubp_engine: assert property (@(posedge clock_i) disable iff (!rst_n)
        eng_o.ubp[UBP_ECHO_MSB:UBP_ECHO_LSB] == 5'h0 && !eng_o.ubp[UBP_ACK])
        else $error("engine-owned page bits leaked");
endmodule

//--- testbench/kra_eng_model.sv
// Behavioural stand-in for the negotiation engine behind the register bank.
// Assumes the bench supplies the engine's levels and pulses through stim_i.
module kra_eng_model
    import kra_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire kra_eng_stat_t stim_i,
    input wire logic [7:0] np_delay_i,
    input wire kra_eng_ctrl_t ctrl_i,
    output kra_eng_stat_t stat_o
);
    // ==========================================================
    // Next page hand-off
    logic [7:0] wait_reg;
    logic taken_reg;

    // Take the page only after np_delay_i cycles, to model a slow engine
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_reg <= 8'h00;
            taken_reg <= 1'b0;
        end else begin
            taken_reg <= 1'b0;
            if (ctrl_i.np_ready && !taken_reg) begin
                if (wait_reg >= np_delay_i) begin
                    taken_reg <= 1'b1;
                    wait_reg <= 8'h00;
                end else begin
                    wait_reg <= wait_reg + 8'h01;
                end
            end else begin
                wait_reg <= 8'h00;
            end
        end
    end

    // Everything else follows the bench's stimulus
    always_comb begin
        stat_o = stim_i;
        stat_o.np_taken = taken_reg;
    end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the auto-negotiation register bank.
// Assumes one 25 MHz clock and the engine model on the far side.
module tb;
    import kra_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    kra_bus_t bus = '0;
    logic [DW-1:0] rdata_o;
    kra_eng_stat_t stim = '0;
    kra_eng_stat_t eng_stat;
    kra_eng_ctrl_t eng_o;
    logic [7:0] np_delay = 8'h00;
    logic [15:0] lfsr_reg = 16'h3779;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] r, d;

    kra_regs kra_regs_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus),
        .rdata_o(rdata_o), .eng_i(eng_stat), .eng_o(eng_o));
    kra_eng_model kra_eng_model_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .stim_i(stim),
        .np_delay_i(np_delay), .ctrl_i(eng_o), .stat_o(eng_stat));

    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #20 clock_i = ~clock_i;
    end

    // Generous ceiling; the sequence needs well under a thousand cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    // ==========================================================
    // Helpers
    function automatic void next_rand(output logic [31:0] v);
        repeat (2) begin
            lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
            v = {v[15:0], lfsr_reg};
        end
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus.wr <= 1'b0;
        #1;
    endtask

    // Optional fec event in the very cycle the read is taken
    task automatic rd(input logic [AW-1:0] a, input logic ev, output logic [DW-1:0] v);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        stim.fec_uncorr <= ev;
        @(posedge clock_i);
        bus.rd <= 1'b0;
        stim.fec_uncorr <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // Writable control bits, with the fault bit taken live from the engine
    function automatic logic [31:0] ctrl_exp(input logic [31:0] w, input logic rf);
        ctrl_exp = (w & 32'h733f0037) | {28'h0, rf, 3'h0};
    endfunction

    // Engine-facing copy; overrides are zero while override is off
    function automatic logic [31:0] eng_exp(input logic [31:0] w);
        logic o;
        o = w[CTL_OVR_EN];
        eng_exp = {16'h0, w[0], w[1], w[2], w[4], o, o ? w[21:16] : 6'h0,
            o ? w[25:24] : 2'h0, o ? w[30:28] : 3'h0};
    endfunction

    // Status word with no sticky events pending
    function automatic logic [31:0] st_exp(input kra_eng_stat_t s);
        st_exp = 32'h0;
        st_exp[ST_READY_MSB:ST_READY_LSB] = s.link_ready;
        st_exp[ST_DONE] = s.done;
        st_exp[ST_RX_IDLE] = s.rx_idle;
        st_exp[ST_ABILITY] = AN_BUILT_IN;
        st_exp[ST_LINK] = s.link_up;
        st_exp[ST_LP_ABILITY] = s.lp_ability;
        st_exp[ST_FEC_NEG] = s.done & s.fec_resolved;
        st_exp[ST_FAIL] = s.seq_fail;
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(10'h300, 1'b0, d);
        chk32(d, 32'h00000001);
        chk1(eng_o.an_en, 1'b1);
        rd(10'h308, 1'b0, d);
        chk32(d, 32'h00000020);
        @(posedge clock_i);
        #1 chk32(rdata_o, 32'h0);
        end_test("reset");
        // Random control words, fault bit toggling underneath
        repeat (8) begin
            next_rand(r);
            stim.local_rf <= r[3];
            wr(10'h300, r);
            chk32({16'h0, eng_o[34:19]}, eng_exp(r));
            rd(10'h300, 1'b0, d);
            chk32(d, ctrl_exp(r, r[3]));
        end
        wr(10'h300, 32'h00040020);
        chk32({26'h0, eng_o.tech}, 32'h4);
        end_test("control");
        // User base page: engine-owned bits must not leak through
        next_rand(r);
        wr(10'h30c, r);
        chk32({16'h0, eng_o.ubp}, {16'h0, r[15:0] & UBP_ENGINE_MASK});
        rd(10'h30c, 1'b0, d);
        chk32(d, {16'h0, r[15:0]});
        wr(10'h3fc, r);
        rd(10'h3fc, 1'b0, d);
        chk32(d, 32'h0);
        end_test("base page");
        // Strobes: reset always, restart only while negotiating
        wr(10'h304, 32'h00000001);
        chk1(eng_o.reset_pulse, 1'b1);
        @(posedge clock_i);
        #1 chk1(eng_o.reset_pulse, 1'b0);
        wr(10'h304, 32'h00000010);
        chk1(eng_o.restart_pulse, 1'b0);
        stim.tx_in_neg <= 1'b1;
        wr(10'h304, 32'h00000010);
        chk1(eng_o.restart_pulse, 1'b1);
        rd(10'h304, 1'b0, d);
        chk32(d, 32'h0);
        stim.tx_in_neg <= 1'b0;
        np_delay <= 8'h14;
        wr(10'h304, 32'h00000100);
        rd(10'h304, 1'b0, d);
        chk32(d, 32'h00000100);
        repeat (30) @(posedge clock_i);
        rd(10'h304, 1'b0, d);
        chk32(d, 32'h0);
        np_delay <= 8'h00;
        wr(10'h304, 32'h00000100);
        repeat (4) @(posedge clock_i);
        rd(10'h304, 1'b0, d);
        chk32(d, 32'h0);
        end_test("strobes");
        // Sticky flags set by pulses, link held after it drops
        @(posedge clock_i);
        stim.link_up <= 1'b1;
        stim.page_rx <= 1'b1;
        stim.rf_sent <= 1'b1;
        @(posedge clock_i);
        stim.link_up <= 1'b0;
        stim.page_rx <= 1'b0;
        stim.rf_sent <= 1'b0;
        rd(10'h308, 1'b0, d);
        chk32(d, 32'h0000006a);
        rd(10'h308, 1'b0, d);
        chk32(d, 32'h00000020);
        // Live levels from random draws; second read has no sticky residue
        repeat (8) begin
            next_rand(r);
            @(posedge clock_i);
            stim.done <= r[0];
            stim.rx_idle <= r[1];
            stim.link_up <= r[2];
            stim.lp_ability <= r[3];
            stim.fec_resolved <= r[4];
            stim.seq_fail <= r[5];
            stim.link_ready <= r[13:8];
            repeat (2) @(posedge clock_i);
            rd(10'h308, 1'b0, d);
            rd(10'h308, 1'b0, d);
            chk32(d, st_exp(stim));
        end
        end_test("status");
        // Uncorrectable block counter: count, clear on read, event in read cycle
        rd(10'h2d0, 1'b0, d);
        next_rand(r);
        @(posedge clock_i);
        stim.fec_uncorr <= 1'b1;
        repeat (r[4:0] + 1) @(posedge clock_i);
        stim.fec_uncorr <= 1'b0;
        rd(10'h2d0, 1'b0, d);
        chk32(d, {27'h0, r[4:0]} + 32'h1);
        rd(10'h2d0, 1'b1, d);
        chk32(d, 32'h0);
        rd(10'h2d0, 1'b0, d);
        chk32(d, 32'h1);
        end_test("counter");
        print_verdict();
    end
endmodule
